// file: design/fcei_pkg.sv
// Types shared by the error and alarm injector modules
// Assumes the field layout held in fcei_regs.svh.
package fcei_pkg;

	typedef enum logic [2:0] {
		ALM_NONE = 3'b000,
		ALM_LR   = 3'b001,
		ALM_LRR  = 3'b010,
		ALM_NOS  = 3'b011,
		ALM_OLS  = 3'b100
	} fcei_alarm_t;

	typedef enum logic [2:0] {
		ERR_NONE = 3'b000,
		ERR_BIT  = 3'b001,
		ERR_SYM  = 3'b010,
		ERR_RRDY = 3'b011,
		ERR_CRC  = 3'b100,
		ERR_BLK  = 3'b101
	} fcei_err_t;

	typedef enum logic [3:0] {
		INS_OFF   = 4'h0,
		INS_MAN   = 4'h1,
		INS_SEC   = 4'h2,
		INS_SEC10 = 4'h3,
		INS_R2    = 4'h4,
		INS_R3    = 4'h5,
		INS_R4    = 4'h6,
		INS_R5    = 4'h7,
		INS_R6    = 4'h8,
		INS_R7    = 4'h9
	} fcei_ins_t;

	typedef enum logic [1:0] {
		MS_STOP = 2'b00,
		MS_RUN  = 2'b01,
		MS_FULL = 2'b10
	} fcei_meas_t;

endpackage : fcei_pkg

// file: design/fcei_regs.svh
// Register offsets, field positions, character codes and timing counts
// Assumes APB byte addressing, one 32-bit word per register.
`ifndef FCEI_REGS_SVH
`define FCEI_REGS_SVH

`define FCEI_OFS_CTRL     8'h00
`define FCEI_OFS_BURST    8'h04
`define FCEI_OFS_CMD      8'h08
`define FCEI_OFS_DEV      8'h0c
`define FCEI_OFS_SID      8'h10
`define FCEI_OFS_DID      8'h14
`define FCEI_OFS_IVAL     8'h18
`define FCEI_OFS_STATUS   8'h1c
`define FCEI_OFS_PATERR   8'h20
`define FCEI_OFS_FRMCNT   8'h24
`define FCEI_OFS_INTCNT   8'h28
`define FCEI_OFS_RECADR   8'h2c

// Control register fields
`define FCEI_CTRL_ALARM   2:0
`define FCEI_CTRL_ERR     5:3
`define FCEI_CTRL_MODE    9:6
`define FCEI_CTRL_LOST    10
`define FCEI_CTRL_ADDRF   11
`define FCEI_CTRL_MEASO   12
`define FCEI_CTRL_CONT    13
`define FCEI_CTRL_B66     14
`define FCEI_CTRL_CRCF    15
`define FCEI_CTRL_MASK    32'h0000_ffff

// Command register bits (write-only pulses)
`define FCEI_CMD_START    0
`define FCEI_CMD_STOP     1
`define FCEI_CMD_TRIG     2

// 8b characters, first character of a word in bits 31:24
`define FCEI_K28_5        8'hbc
`define FCEI_D9_2         8'h49
`define FCEI_D31_5        8'hbf
`define FCEI_D21_1        8'h35
`define FCEI_D21_2        8'h55
`define FCEI_D5_2         8'h45
`define FCEI_D10_4        8'h8a
`define FCEI_D21_4        8'h95
`define FCEI_D10_2        8'h4a
`define FCEI_KMASK_OS     4'h8

// Receive filter values
`define FCEI_RCTL_FC4     8'h00
`define FCEI_TYPE_VU      8'he0

// Timing and storage
`define FCEI_CLK_HZ       200000000
`define FCEI_TICK_S       1
`define FCEI_MEM_BYTES    (64*1024*1024)
`define FCEI_REC_BYTES    16
`define FCEI_IVAL_NONE    5'h10

`endif

// file: design/fcei_sched.sv
// Error insertion scheduler: keeps a count of errors still owed
// Assumes secTick and blockTick are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
`include "fcei_regs.svh"

module fcei_sched (
	input  wire logic              ref_clk,
	input  wire logic              nrst,
	input  wire fcei_pkg::fcei_ins_t mode,
	input  wire logic [15:0]       burstLen,
	input  wire logic              trig,
	input  wire logic              secTick,
	input  wire logic              blockTick,
	input  wire logic              take,
	output logic                   avail
);

	logic [17:0] pend_r,   pend_nxt;
	logic [23:0] blkCnt_r, blkCnt_nxt;
	logic [3:0]  secCnt_r, secCnt_nxt;
	logic        fire;

	function automatic logic [23:0] blocksPerBurst(input fcei_pkg::fcei_ins_t m);
		case (m)
			fcei_pkg::INS_R2: blocksPerBurst = 24'd100;
			fcei_pkg::INS_R3: blocksPerBurst = 24'd1000;
			fcei_pkg::INS_R4: blocksPerBurst = 24'd10000;
			fcei_pkg::INS_R5: blocksPerBurst = 24'd100000;
			fcei_pkg::INS_R6: blocksPerBurst = 24'd1000000;
			fcei_pkg::INS_R7: blocksPerBurst = 24'd10000000;
			default:          blocksPerBurst = 24'd0;
		endcase
	endfunction : blocksPerBurst

	always_comb begin
		fire       = 1'b0;
		blkCnt_nxt = blkCnt_r;
		secCnt_nxt = secCnt_r;
		case (mode)
			fcei_pkg::INS_OFF:   fire = 1'b0;
			fcei_pkg::INS_MAN:   fire = trig;
			fcei_pkg::INS_SEC:   fire = secTick;
			fcei_pkg::INS_SEC10: begin
				fire = secTick && (secCnt_r == 4'd9);
				if (secTick)
					secCnt_nxt = (secCnt_r == 4'd9) ? 4'd0 : secCnt_r + 4'd1;
			end
			default: begin
				if (blockTick) begin
					fire       = (blkCnt_r == blocksPerBurst(mode) - 24'd1);
					blkCnt_nxt = fire ? 24'd0 : blkCnt_r + 24'd1;
				end
			end
		endcase
		// A new burst adds to what is still owed; a take in the same cycle still counts
		if (mode == fcei_pkg::INS_OFF)
			pend_nxt = 18'd0;
		else
			pend_nxt = pend_r + (fire ? {2'b00, burstLen} : 18'd0)
				- ((take && pend_r != 18'd0) ? 18'd1 : 18'd0);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			pend_r   <= 18'd0;
			blkCnt_r <= 24'd0;
			secCnt_r <= 4'd0;
		end else begin
			pend_r   <= pend_nxt;
			blkCnt_r <= blkCnt_nxt;
			secCnt_r <= secCnt_nxt;
		end
	end

	assign avail = (pend_r != 18'd0);

	////////////////////////////////////////////////////////////////////////
	man_burst_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(mode == fcei_pkg::INS_MAN && trig && !take && pend_r == 18'd0)
		|=> pend_r == {2'b00, $past(burstLen)})
		else $error("manual trigger did not load burst length");

	off_clear_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		mode == fcei_pkg::INS_OFF |=> !avail)
		else $error("errors pending while insertion is off");

endmodule : fcei_sched

// file: design/fcei_top.sv
// Fibre Channel test port error/alarm injector and receive checker top
// Assumes an APB master on ref_clk and a word-wide tx/rx datapath.
`timescale 1ns/1ps
`include "fcei_regs.svh"

// Function
// - Selected alarm sent continuously; none sends none
// - Link reset sends its ordered set
// - Link reset response sends its ordered set
// - Not operational sends its ordered set
// - Offline sends its ordered set
// - Receiver-ready error sends receiver-ready signal
// - Bit error flips one payload bit
// - Symbol error sends bad code; not in 64b/66b
// - CRC error flips one CRC bit if present
// - Block error only in 64b/66b modes
// - Manual trigger inserts burst; off inserts none
// - Burst inserted once every second
// - Burst inserted once every ten seconds
// - Burst per ten-to-the-n blocks
// - Signed deviation shifts transmit frequency
// - Interval length selectable from fixed list
// - Lost frame bits added to pattern errors
// - Address filter matches ids, routing, type
// - No filter: count FC-4 routing frames
// - Measuring-only gates error ratio alarm
// - Full store stops or wraps with event
module fcei_top #(
	parameter int unsigned SEC_CYC  = `FCEI_TICK_S * `FCEI_CLK_HZ,
	parameter int unsigned MEM_RECS = `FCEI_MEM_BYTES / `FCEI_REC_BYTES
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic [31:0] txInData,
	input  wire logic [3:0]  txInK,
	input  wire logic        txInValid,
	input  wire logic        txInFrame,
	input  wire logic        txInCrc,
	input  wire logic        txInIdle,
	input  wire logic        txBlockTick,
	output logic [31:0]      txData,
	output logic [3:0]       txK,
	output logic             txValid,
	output logic             txSymErr,
	output logic             txBlkErr,
	output logic [15:0]      txDevTrim,
	input  wire logic        rxFrameEnd,
	input  wire logic [23:0] rxSid,
	input  wire logic [23:0] rxDid,
	input  wire logic [7:0]  rxRctl,
	input  wire logic [7:0]  rxType,
	input  wire logic        rxFrameLost,
	input  wire logic [15:0] rxLostBits,
	input  wire logic [15:0] rxBitErrs,
	input  wire logic        rxBerRaw,
	output logic             berAlarm,
	output logic             recWrite,
	output logic [31:0]      recAddr,
	output logic             memFullEvent,
	output logic             measRunning
);

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic [15:0] ctrl_r,  ctrl_nxt;
	logic [15:0] burst_r, burst_nxt;
	logic [15:0] dev_r,   dev_nxt;
	logic [23:0] sid_r,   sid_nxt;
	logic [23:0] did_r,   did_nxt;
	logic [4:0]  ival_r,  ival_nxt;
	logic [31:0] rdat_r,  rdat_nxt;
	logic        wrEn;
	logic        mapped;
	logic        cmdStart;
	logic        cmdStop;
	logic        cmdTrig;

	// Measurement state
	fcei_pkg::fcei_meas_t ms_r, ms_nxt;
	logic [31:0] secDiv_r, secDiv_nxt;
	logic [15:0] ivSec_r,  ivSec_nxt;
	logic [31:0] patErr_r, patErr_nxt;
	logic [31:0] frmCnt_r, frmCnt_nxt;
	logic [31:0] intCnt_r, intCnt_nxt;
	logic [31:0] recAddr_r, recAddr_nxt;
	logic        recWrite_r, recWrite_nxt;
	logic        memFull_r, memFull_nxt;
	logic        fullEv_r,  fullEv_nxt;
	logic        berAlarm_r, berAlarm_nxt;
	logic        secTick;
	logic        ivEnd;
	logic        frameOk;
	logic        take;
	logic        avail;

	// Interval length in seconds; zero means no intervals
	function automatic logic [15:0] ivalSecs(input logic [4:0] sel);
		case (sel)
			5'd0:    ivalSecs = 16'd1;
			5'd1:    ivalSecs = 16'd2;
			5'd2:    ivalSecs = 16'd5;
			5'd3:    ivalSecs = 16'd10;
			5'd4:    ivalSecs = 16'd15;
			5'd5:    ivalSecs = 16'd30;
			5'd6:    ivalSecs = 16'd60;
			5'd7:    ivalSecs = 16'd300;
			5'd8:    ivalSecs = 16'd600;
			5'd9:    ivalSecs = 16'd900;
			5'd10:   ivalSecs = 16'd1800;
			5'd11:   ivalSecs = 16'd3600;
			5'd12:   ivalSecs = 16'd7200;
			5'd13:   ivalSecs = 16'd14400;
			5'd14:   ivalSecs = 16'd21600;
			5'd15:   ivalSecs = 16'd43200;
			default: ivalSecs = 16'd0;
		endcase
	endfunction : ivalSecs

	// Zero-wait slave: every access completes in its first access cycle
	assign wrEn     = psel && penable && pwrite && mapped;
	assign cmdStart = wrEn && paddr == `FCEI_OFS_CMD && pwdata[`FCEI_CMD_START];
	assign cmdStop  = wrEn && paddr == `FCEI_OFS_CMD && pwdata[`FCEI_CMD_STOP];
	assign cmdTrig  = wrEn && paddr == `FCEI_OFS_CMD && pwdata[`FCEI_CMD_TRIG];
	assign pready   = 1'b1;
	assign pslverr  = psel && penable && !mapped;
	assign prdata   = rdat_r;

	always_comb begin
		mapped    = 1'b1;
		ctrl_nxt  = ctrl_r;
		burst_nxt = burst_r;
		dev_nxt   = dev_r;
		sid_nxt   = sid_r;
		did_nxt   = did_r;
		ival_nxt  = ival_r;
		rdat_nxt  = rdat_r;
		case (paddr)
			`FCEI_OFS_CTRL:   rdat_nxt = {16'h0000, ctrl_r};
			`FCEI_OFS_BURST:  rdat_nxt = {16'h0000, burst_r};
			`FCEI_OFS_CMD:    rdat_nxt = 32'h0000_0000;
			`FCEI_OFS_DEV:    rdat_nxt = {16'h0000, dev_r};
			`FCEI_OFS_SID:    rdat_nxt = {8'h00, sid_r};
			`FCEI_OFS_DID:    rdat_nxt = {8'h00, did_r};
			`FCEI_OFS_IVAL:   rdat_nxt = {27'h0, ival_r};
			`FCEI_OFS_STATUS: rdat_nxt = {26'h0, avail, berAlarm_r, memFull_r,
				ms_r == fcei_pkg::MS_FULL, ms_r == fcei_pkg::MS_RUN, 1'b0};
			`FCEI_OFS_PATERR: rdat_nxt = patErr_r;
			`FCEI_OFS_FRMCNT: rdat_nxt = frmCnt_r;
			`FCEI_OFS_INTCNT: rdat_nxt = intCnt_r;
			`FCEI_OFS_RECADR: rdat_nxt = recAddr_r;
			default: begin
				mapped   = 1'b0;
				rdat_nxt = 32'h0000_0000;
			end
		endcase
		if (!(psel && !penable && !pwrite))
			rdat_nxt = rdat_r;
		if (wrEn) begin
			case (paddr)
				`FCEI_OFS_CTRL:  ctrl_nxt  = pwdata[15:0];
				`FCEI_OFS_BURST: burst_nxt = pwdata[15:0];
				`FCEI_OFS_DEV:   dev_nxt   = pwdata[15:0];
				`FCEI_OFS_SID:   sid_nxt   = pwdata[23:0];
				`FCEI_OFS_DID:   did_nxt   = pwdata[23:0];
				`FCEI_OFS_IVAL:  ival_nxt  = (pwdata[4:0] > `FCEI_IVAL_NONE) ?
					`FCEI_IVAL_NONE : pwdata[4:0];
				default:         ctrl_nxt  = ctrl_r;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_r  <= 16'h0000;
			burst_r <= 16'h0001;
			dev_r   <= 16'h0000;
			sid_r   <= 24'h000000;
			did_r   <= 24'h000000;
			ival_r  <= 5'h00;
			rdat_r  <= 32'h0000_0000;
		end else begin
			ctrl_r  <= ctrl_nxt;
			burst_r <= burst_nxt;
			dev_r   <= dev_nxt;
			sid_r   <= sid_nxt;
			did_r   <= did_nxt;
			ival_r  <= ival_nxt;
			rdat_r  <= rdat_nxt;
		end
	end

	// Two's complement trim to the synthesiser: above zero speeds the line up
	assign txDevTrim = dev_r;

	////////////////////////////////////////////////////////////////////////
	// Transmit side
	fcei_sched u_sched (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.mode      (fcei_pkg::fcei_ins_t'(ctrl_r[`FCEI_CTRL_MODE])),
		.burstLen  (burst_r),
		.trig      (cmdTrig),
		.secTick   (secTick),
		.blockTick (txBlockTick),
		.take      (take),
		.avail     (avail)
	);

	fcei_tx_ins u_tx (
		.ref_clk     (ref_clk),
		.nrst        (nrst),
		.inData      (txInData),
		.inK         (txInK),
		.inValid     (txInValid),
		.inFrame     (txInFrame),
		.inCrc       (txInCrc),
		.inIdle      (txInIdle),
		.alarm       (fcei_pkg::fcei_alarm_t'(ctrl_r[`FCEI_CTRL_ALARM])),
		.errType     (fcei_pkg::fcei_err_t'(ctrl_r[`FCEI_CTRL_ERR])),
		.mode64      (ctrl_r[`FCEI_CTRL_B66]),
		.crcFraming  (ctrl_r[`FCEI_CTRL_CRCF]),
		.avail       (avail),
		.take        (take),
		.outData_r   (txData),
		.outK_r      (txK),
		.outValid_r  (txValid),
		.outSymErr_r (txSymErr),
		.outBlkErr_r (txBlkErr)
	);

	////////////////////////////////////////////////////////////////////////
	// Receive checking, intervals and result storage
	assign secTick = (secDiv_r == SEC_CYC - 1);
	assign ivEnd   = secTick && ivalSecs(ival_r) != 16'd0
		&& ivSec_r == ivalSecs(ival_r) - 16'd1;
	assign frameOk = ctrl_r[`FCEI_CTRL_ADDRF] ?
		(rxSid == sid_r && rxDid == did_r && rxRctl == `FCEI_RCTL_FC4
			&& rxType == `FCEI_TYPE_VU) :
		(rxRctl == `FCEI_RCTL_FC4);

	always_comb begin
		ms_nxt       = ms_r;
		secDiv_nxt   = secTick ? 32'd0 : secDiv_r + 32'd1;
		ivSec_nxt    = ivSec_r;
		patErr_nxt   = patErr_r;
		frmCnt_nxt   = frmCnt_r;
		intCnt_nxt   = intCnt_r;
		recAddr_nxt  = recAddr_r;
		recWrite_nxt = 1'b0;
		memFull_nxt  = memFull_r;
		fullEv_nxt   = 1'b0;
		case (ms_r)
			fcei_pkg::MS_STOP, fcei_pkg::MS_FULL: begin
				if (cmdStart) begin
					ms_nxt      = fcei_pkg::MS_RUN;
					ivSec_nxt   = 16'd0;
					patErr_nxt  = 32'd0;
					frmCnt_nxt  = 32'd0;
					intCnt_nxt  = 32'd0;
					recAddr_nxt = 32'd0;
					memFull_nxt = 1'b0;
					secDiv_nxt  = 32'd0;
				end
			end
			fcei_pkg::MS_RUN: begin
				if (rxFrameEnd && frameOk)
					frmCnt_nxt = frmCnt_r + 32'd1;
				patErr_nxt = patErr_r + {16'h0000, rxBitErrs}
					+ ((rxFrameLost && ctrl_r[`FCEI_CTRL_LOST]) ?
						{16'h0000, rxLostBits} : 32'd0);
				if (secTick)
					ivSec_nxt = ivEnd ? 16'd0 : ivSec_r + 16'd1;
				if (ivEnd) begin
					recWrite_nxt = 1'b1;
					intCnt_nxt   = intCnt_r + 32'd1;
					if (recAddr_r == MEM_RECS - 1) begin
						recAddr_nxt = 32'd0;
						if (ctrl_r[`FCEI_CTRL_CONT]) begin
							memFull_nxt = 1'b1;
							fullEv_nxt  = 1'b1;
						end else
							ms_nxt = fcei_pkg::MS_FULL;
					end else
						recAddr_nxt = recAddr_r + 32'd1;
				end
				if (cmdStop)
					ms_nxt = fcei_pkg::MS_STOP;
			end
			default: ms_nxt = fcei_pkg::MS_STOP;
		endcase
		berAlarm_nxt = rxBerRaw && (!ctrl_r[`FCEI_CTRL_MEASO]
			|| ms_r == fcei_pkg::MS_RUN);
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ms_r       <= fcei_pkg::MS_STOP;
			secDiv_r   <= 32'd0;
			ivSec_r    <= 16'd0;
			patErr_r   <= 32'd0;
			frmCnt_r   <= 32'd0;
			intCnt_r   <= 32'd0;
			recAddr_r  <= 32'd0;
			recWrite_r <= 1'b0;
			memFull_r  <= 1'b0;
			fullEv_r   <= 1'b0;
			berAlarm_r <= 1'b0;
		end else begin
			ms_r       <= ms_nxt;
			secDiv_r   <= secDiv_nxt;
			ivSec_r    <= ivSec_nxt;
			patErr_r   <= patErr_nxt;
			frmCnt_r   <= frmCnt_nxt;
			intCnt_r   <= intCnt_nxt;
			recAddr_r  <= recAddr_nxt;
			recWrite_r <= recWrite_nxt;
			memFull_r  <= memFull_nxt;
			fullEv_r   <= fullEv_nxt;
			berAlarm_r <= berAlarm_nxt;
		end
	end

	assign berAlarm     = berAlarm_r;
	assign recWrite     = recWrite_r;
	assign recAddr      = recAddr_r;
	assign memFullEvent = fullEv_r;
	assign measRunning  = (ms_r == fcei_pkg::MS_RUN);

	////////////////////////////////////////////////////////////////////////
	ber_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ctrl_r[`FCEI_CTRL_MEASO] && ms_r != fcei_pkg::MS_RUN) |=> !berAlarm)
		else $error("error ratio alarm shown while not measuring");

	lost_add_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ms_r == fcei_pkg::MS_RUN && !cmdStop && rxFrameLost && ctrl_r[`FCEI_CTRL_LOST])
		|=> patErr_r == $past(patErr_r) + {16'h0000, $past(rxLostBits)}
			+ {16'h0000, $past(rxBitErrs)})
		else $error("lost frame bits not added");

	filt_count_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ms_r == fcei_pkg::MS_RUN && rxFrameEnd && ctrl_r[`FCEI_CTRL_ADDRF]
			&& rxType != `FCEI_TYPE_VU) |=> frmCnt_r == $past(frmCnt_r))
		else $error("filtered frame was counted");

	full_stop_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ms_r == fcei_pkg::MS_RUN && ivEnd && !cmdStop && recAddr_r == MEM_RECS - 1
			&& !ctrl_r[`FCEI_CTRL_CONT]) |=> ms_r == fcei_pkg::MS_FULL ##1 !recWrite)
		else $error("full store did not stop measurement");

	unmapped_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(psel && penable && !mapped) |-> pslverr && pready)
		else $error("unmapped access not flagged");

endmodule : fcei_top

// file: design/fcei_tx_ins.sv
// Transmit word inserter: alarms, receiver-ready and error corruption
// Assumes one 4-character word per cycle with per-character K flags.
`timescale 1ns/1ps
`include "fcei_regs.svh"

module fcei_tx_ins (
	input  wire logic                  ref_clk,
	input  wire logic                  nrst,
	input  wire logic [31:0]           inData,
	input  wire logic [3:0]            inK,
	input  wire logic                  inValid,
	input  wire logic                  inFrame,
	input  wire logic                  inCrc,
	input  wire logic                  inIdle,
	input  wire fcei_pkg::fcei_alarm_t alarm,
	input  wire fcei_pkg::fcei_err_t   errType,
	input  wire logic                  mode64,
	input  wire logic                  crcFraming,
	input  wire logic                  avail,
	output logic                       take,
	output logic [31:0]                outData_r,
	output logic [3:0]                 outK_r,
	output logic                       outValid_r,
	output logic                       outSymErr_r,
	output logic                       outBlkErr_r
);

	logic [31:0] data_nxt;
	logic [3:0]  k_nxt;
	logic        symErr_nxt;
	logic        blkErr_nxt;
	logic        spot;

	function automatic logic [31:0] osWord(input logic [7:0] c1, input logic [7:0] c2,
		input logic [7:0] c3);
		osWord = {`FCEI_K28_5, c1, c2, c3};
	endfunction : osWord

	always_comb begin
		case (errType)
			fcei_pkg::ERR_BIT:  spot = inFrame && !inCrc;
			fcei_pkg::ERR_SYM:  spot = !mode64;
			fcei_pkg::ERR_RRDY: spot = inIdle && alarm == fcei_pkg::ALM_NONE;
			fcei_pkg::ERR_CRC:  spot = inCrc && crcFraming;
			fcei_pkg::ERR_BLK:  spot = mode64;
			default:            spot = 1'b0;
		endcase
		take       = avail && inValid && spot;
		data_nxt   = inData;
		k_nxt      = inK;
		symErr_nxt = 1'b0;
		blkErr_nxt = 1'b0;
		if (take) begin
			case (errType)
				fcei_pkg::ERR_BIT, fcei_pkg::ERR_CRC: data_nxt = inData ^ 32'h0000_0001;
				fcei_pkg::ERR_SYM:  symErr_nxt = 1'b1;
				fcei_pkg::ERR_BLK:  blkErr_nxt = 1'b1;
				fcei_pkg::ERR_RRDY: begin
					data_nxt = osWord(`FCEI_D21_4, `FCEI_D10_2, `FCEI_D10_2);
					k_nxt    = `FCEI_KMASK_OS;
				end
				default: data_nxt = inData;
			endcase
		end
		// A selected alarm owns the line on every word
		if (inValid && alarm != fcei_pkg::ALM_NONE) begin
			k_nxt = `FCEI_KMASK_OS;
			case (alarm)
				fcei_pkg::ALM_LR:  data_nxt = osWord(`FCEI_D9_2, `FCEI_D31_5, `FCEI_D9_2);
				fcei_pkg::ALM_LRR: data_nxt = osWord(`FCEI_D21_1, `FCEI_D31_5, `FCEI_D9_2);
				fcei_pkg::ALM_NOS: data_nxt = osWord(`FCEI_D21_2, `FCEI_D31_5, `FCEI_D5_2);
				fcei_pkg::ALM_OLS: data_nxt = osWord(`FCEI_D21_1, `FCEI_D10_4, `FCEI_D21_2);
				default:           data_nxt = inData;
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			outData_r   <= 32'h0000_0000;
			outK_r      <= 4'h0;
			outValid_r  <= 1'b0;
			outSymErr_r <= 1'b0;
			outBlkErr_r <= 1'b0;
		end else begin
			outData_r   <= data_nxt;
			outK_r      <= k_nxt;
			outValid_r  <= inValid;
			outSymErr_r <= symErr_nxt;
			outBlkErr_r <= blkErr_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	lr_word_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(inValid && alarm == fcei_pkg::ALM_LR)
		|=> outData_r == 32'hbc49_bf49 && outK_r == 4'h8)
		else $error("link reset ordered set wrong");

	rrdy_word_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(take && errType == fcei_pkg::ERR_RRDY) |=> outData_r == 32'hbc95_4a4a)
		else $error("receiver ready word wrong");

	bit_flip_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		(take && errType == fcei_pkg::ERR_BIT && alarm == fcei_pkg::ALM_NONE)
		|=> outData_r == ($past(inData) ^ 32'h0000_0001))
		else $error("bit error not a single flip");

	sym_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
		outSymErr_r |-> !$past(mode64))
		else $error("symbol error sent in 64b/66b mode");

endmodule : fcei_tx_ins

// file: verification/fcei_fc_peer.sv
// Far-end FC device model: reports received and lost frames
// Assumes the bench pulses fire or lose for one ref_clk cycle.
`timescale 1ns/1ps
module fcei_fc_peer (
	input  wire logic        ref_clk,
	input  wire logic        fire,
	input  wire logic        lose,
	input  wire logic [7:0]  rctl,
	input  wire logic [7:0]  typ,
	output logic             rxFrameEnd,
	output logic             rxFrameLost,
	output logic [23:0]      rxSid,
	output logic [23:0]      rxDid,
	output logic [7:0]       rxRctl,
	output logic [7:0]       rxType,
	output logic [15:0]      rxLostBits
);
	logic [23:0] junk = 24'h0;
	// Fields churn outside a report, so stale values never pass
	always @(posedge ref_clk) junk <= junk + 24'h9e3779;
	assign rxFrameEnd  = fire;
	assign rxFrameLost = lose;
	assign rxSid       = fire ? 24'h0a0b0c : junk;
	assign rxDid       = fire ? 24'h0d0e0f : ~junk;
	assign rxRctl      = fire ? rctl : junk[7:0];
	assign rxType      = fire ? typ : junk[15:8];
	// Lost frame holds 8 content bytes, delimiters not counted
	assign rxLostBits  = lose ? 16'h0040 : junk[15:0];
endmodule : fcei_fc_peer

// file: verification/fcei_top_tb.sv
// Bench for fcei_top: APB access, tx word stream, rx frame counting
// Assumes fcei_fc_peer stands for the far-end device on the rx side.
`timescale 1ns/1ps
`include "fcei_regs.svh"
module fcei_top_tb;
	logic        ref_clk, nrst, psel, penable, pwrite, pready, pslverr, se;
	logic        txInValid, txInFrame, txInCrc, txInIdle, txValid, txSymErr, txBlkErr;
	logic        fire, lose, rxFrameEnd, rxFrameLost, ber, blk, berAlarm, measRunning;
	logic [7:0]  paddr, rctl, rxRctl, rxType, typ = 8'he0;
	logic [31:0] pwdata, prdata, rd, txInData, txData, od, dx;
	logic [3:0]  txInK, txK;
	logic [23:0] rxSid, rxDid;
	logic [15:0] rxLostBits, txDevTrim;
	logic [31:0] alm [1:4] = '{32'hbc49bf49, 32'hbc35bf49, 32'hbc55bf45, 32'hbc358a55};
	logic [31:0] ctl [5]   = '{32'h48, 32'h8060, 32'h58, 32'h50, 32'h4068};
	logic [31:0] exq [5]   = '{32'h1, 32'h1, 32'hbc954a4a, 32'h8000_0000, 32'h4000_0000};
	int          errors = 0, samples_checked = 0, seed = 81, hits, burst;
	fcei_top #(.SEC_CYC(20), .MEM_RECS(4)) uut (.ref_clk, .nrst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .txInData, .txInK, .txInValid,
		.txInFrame, .txInCrc, .txInIdle, .txBlockTick(blk), .txData, .txK, .txValid,
		.txSymErr, .txBlkErr, .txDevTrim, .rxFrameEnd, .rxSid, .rxDid, .rxRctl, .rxType,
		.rxFrameLost, .rxLostBits, .rxBitErrs(16'h0), .rxBerRaw(ber), .berAlarm,
		.recWrite(), .recAddr(), .memFullEvent(), .measRunning);
	fcei_fc_peer peer (.ref_clk, .fire, .lose, .rctl, .typ, .rxFrameEnd, .rxFrameLost, .rxSid,
		.rxDid, .rxRctl, .rxType, .rxLostBits);
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		{psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		se = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb
	// Kind 0 payload, 1 CRC word, 2 idle set; output lags input by one word
	task automatic run(input int cnt, input int kind, input logic [31:0] a);
		logic [31:0] prev;
		hits = 0;
		prev = 32'h0;
		for (int j = 0; j <= cnt; j++) begin
			@(posedge ref_clk);
			txInData <= (kind == 2) ? 32'hbc95b5b5 : $random(seed);
			txInK <= (kind == 2) ? 4'h8 : 4'h0;
			{txInValid, txInFrame, txInCrc, txInIdle} <= {j < cnt, kind == 0, kind == 1, kind == 2};
			#1;
			if (j > 0 && a !== 32'h0) begin
				chk(txData, a);
				chk({27'h0, txValid, txK}, 32'h18);
			end
			if (j > 0 && (txData !== prev || txSymErr || txBlkErr)) begin
				hits++;
				od = txData;
				dx = (txData ^ prev) | {txSymErr, txBlkErr, 30'h0};
			end
			prev = txInData;
		end
	endtask : run
	task automatic frm(input logic [7:0] r, input logic l);
		@(posedge ref_clk);
		{fire, lose, rctl} <= {!l, l, r};
		@(posedge ref_clk);
		{fire, lose} <= 2'b00;
	endtask : frm
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : stop_test
	////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	initial begin
		repeat (6000) @(posedge ref_clk);
		errors++;
		stop_test();
	end
	initial begin
		{nrst, psel, penable, pwrite, paddr, pwdata, fire, lose, rctl, ber, blk} = '0;
		{txInData, txInK, txInValid, txInFrame, txInCrc, txInIdle} = '0;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		apb(0, `FCEI_OFS_BURST, 0);
		chk(rd, 32'h1);
		apb(0, 8'h40, 0);
		chk({31'h0, se}, 32'h1);
		for (int a = 1; a <= 4; a++) begin
			apb(1, `FCEI_OFS_CTRL, a);
			run(6, 0, alm[a]);
		end
		apb(1, `FCEI_OFS_CTRL, 32'h08);
		apb(1, `FCEI_OFS_CMD, 32'h4);
		run(8, 0, 0);
		chk(hits, 0);
		$display("alarm test done");
		burst = ($random(seed) & 3) + 2;
		apb(1, `FCEI_OFS_BURST, burst);
		for (int k = 0; k < 5; k++) begin
			apb(1, `FCEI_OFS_CTRL, ctl[k]);
			apb(1, `FCEI_OFS_CMD, 32'h4);
			run(10, k, 0);
			chk(hits, burst);
			chk(k == 2 ? od : dx, exq[k]);
		end
		apb(1, `FCEI_OFS_DEV, 32'hfff6);
		@(posedge ref_clk);
		chk({16'h0, txDevTrim}, 32'hfff6);
		apb(1, `FCEI_OFS_CTRL, 32'hc8);
		for (int i = 0; i < 2; i++) begin
			repeat (30 + 150 * i) @(posedge ref_clk);
			apb(0, `FCEI_OFS_STATUS, 0);
			chk(rd, 32'h20 * i);
		end
		apb(1, `FCEI_OFS_CTRL, 32'h08);
		apb(1, `FCEI_OFS_CTRL, 32'h88);
		repeat (30) @(posedge ref_clk);
		apb(0, `FCEI_OFS_STATUS, 0);
		chk(rd, 32'h20);
		apb(1, `FCEI_OFS_CTRL, 32'h08);
		apb(1, `FCEI_OFS_CTRL, 32'h108);
		for (int i = 0; i < 2; i++) begin
			blk <= 1'b1;
			repeat (99 - 98 * i) @(posedge ref_clk);
			blk <= 1'b0;
			apb(0, `FCEI_OFS_STATUS, 0);
			chk(rd, 32'h20 * i);
		end
		$display("error test done");
		apb(1, `FCEI_OFS_CTRL, 32'h400);
		apb(1, `FCEI_OFS_CMD, 32'h1);
		frm(8'h00, 0);
		frm(8'h01, 0);
		frm(8'h00, 1);
		apb(0, `FCEI_OFS_PATERR, 0);
		chk(rd, 32'h40);
		apb(1, `FCEI_OFS_SID, 32'h0a0b0c);
		apb(1, `FCEI_OFS_DID, 32'h0d0e0f);
		apb(1, `FCEI_OFS_CTRL, 32'h800);
		frm(8'h00, 0);
		typ <= 8'h20;
		frm(8'h00, 0);
		apb(0, `FCEI_OFS_FRMCNT, 0);
		chk(rd, 32'h2);
		apb(1, `FCEI_OFS_CTRL, 32'h1000);
		ber <= 1'b1;
		repeat (100) @(posedge ref_clk);
		apb(0, `FCEI_OFS_STATUS, 0);
		chk(rd, 32'h04);
		apb(1, `FCEI_OFS_CTRL, 32'h3000);
		apb(1, `FCEI_OFS_CMD, 32'h1);
		repeat (100) @(posedge ref_clk);
		apb(0, `FCEI_OFS_STATUS, 0);
		chk(rd, 32'h1a);
		chk({30'h0, measRunning, berAlarm}, 32'h3);
		$display("receive test done");
		stop_test();
	end
endmodule : fcei_top_tb
